/* src/sar_adc_defs.svh */
// timing and width constants for the sar converter control block
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH
`define RESULT_BITS          16
`define CLK_PERIOD_PS        5000
`define CONV_TIME_MAX_NS     527
`define CONV_CYCLES          ((`CONV_TIME_MAX_NS * 1000) / `CLK_PERIOD_PS)
`define RESTART_GUARD_NS     40
`define RESTART_GUARD_CYCLES ((`RESTART_GUARD_NS * 1000) / `CLK_PERIOD_PS)
`define POR_WAIT_US          20
`endif

/* src/sar_adc_pkg.sv */
// types for the sar converter control block
package sar_adc_pkg;
  typedef enum logic [1:0] {ST_ACQUIRE, ST_CONVERT} conv_state_t;
endpackage

/* src/sar_adc_conversion_and_serial_readout.sv */
// sar converter control, conversion sequencing and serial readout
//
// What this block does
// - chain select low: shared pin enables or disables the serial output
// - chain select high: shared pin is the daisy chain serial input
// - rising edge on convert strobe wakes device and starts a conversion
// - busy goes high at conversion start and low at its end
// - when enabled, one bit leaves per serial clock rising edge, msb first
// - output carries own result or, in chain mode, upstream chain data
// - result is unsigned straight binary, zero input gives all zeros
// - device alternates acquisition and a conversion begun on strobe edge
// - sixteen binary weighted trial steps decide one bit each, msb down
// - finished sixteen bit code is loaded into the output shifter
// - readout belongs to the conversion just finished, no latency
// - conversion is timed internally; host only watches busy
// - device powers down automatically between conversions
// - a running conversion is never restarted by further strobe edges
// - msb is driven when conversion ends until first serial clock edge
// - last result may be shifted out while powered down
`timescale 1ns/1ps
`include "sar_adc_defs.svh"

module sar_adc_conversion_and_serial_readout #(
  parameter int RESULT_BITS = `RESULT_BITS,
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic                   convert_strobe_i,
  input  wire logic                   chain_select_i,
  input  wire logic                   read_enable_or_chain_in_i,
  input  wire logic                   sck_i,
  input  wire logic                   comparator_i,
  output logic [RESULT_BITS-1:0]      sampling_cap_dac_o,
  output logic                        sample_switch_o,
  output logic                        power_up_o,
  output logic                        busy_o,
  output logic                        sdo_o,
  output logic                        sdo_oe_n_o
);

  localparam int STEP_CYCLES = CONV_CYCLES / RESULT_BITS;
  localparam int CW          = $clog2(CONV_CYCLES + 1);
  localparam int BW          = $clog2(RESULT_BITS + 1);

  // refuse sizes the sequencer cannot step through
  if (RESULT_BITS < 2 || RESULT_BITS > 64)
  begin : g_bad_width
    $error("result width out of range");
  end
  if (STEP_CYCLES < 1)
  begin : g_bad_time
    $error("conversion time shorter than one cycle per bit");
  end

  // ==========================================================
  // input synchronisers, two flops each for strobe, chain select, shared pin and serial clock; the comparator is used directly
  localparam int PIN_CNV  = 0;
  localparam int PIN_CHN  = 1;
  localparam int PIN_RDL  = 2;
  localparam int PIN_SCK  = 3;
  localparam int PINS     = 4;
  // the shared pin idles high so the output starts disabled
  localparam logic [PINS-1:0] PIN_IDLE = 4'h4;

  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_sync;

  assign pin_raw[PIN_CNV] = convert_strobe_i;
  assign pin_raw[PIN_CHN] = chain_select_i;
  assign pin_raw[PIN_RDL] = read_enable_or_chain_in_i;
  assign pin_raw[PIN_SCK] = sck_i;

  for (genvar gi = 0; gi < PINS; gi++)
  begin : g_sync
    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    always_comb
    begin
      stage_next = {stage_reg[0], pin_raw[gi]};
    end

    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
        stage_reg <= {2{PIN_IDLE[gi]}};
      else
        stage_reg <= stage_next;
    end

    assign pin_sync[gi] = stage_reg[1];
  end

  // ==========================================================
  // edge detection on the synchronised strobe and serial clock
  logic cnv_last_reg, cnv_last_next;
  logic sck_last_reg, sck_last_next;

  always_comb
  begin
    cnv_last_next = pin_sync[PIN_CNV];
    sck_last_next = pin_sync[PIN_SCK];
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cnv_last_reg <= 1'b0;
      sck_last_reg <= 1'b0;
    end
    else
    begin
      cnv_last_reg <= cnv_last_next;
      sck_last_reg <= sck_last_next;
    end
  end

  logic cnv_rise;
  logic sck_rise;
  logic chain_mode;
  logic pin_level;

  assign cnv_rise   = pin_sync[PIN_CNV] & ~cnv_last_reg;
  assign sck_rise   = pin_sync[PIN_SCK] & ~sck_last_reg;
  assign chain_mode = pin_sync[PIN_CHN];
  assign pin_level  = pin_sync[PIN_RDL];

  // ==========================================================
  // conversion sequencer
  function automatic logic [RESULT_BITS-1:0] bit_mask(input logic [BW-1:0] idx);
    logic [RESULT_BITS-1:0] m;
    m = '0;
    m[idx[$clog2(RESULT_BITS)-1:0]] = 1'b1;
    return m;
  endfunction

  // keep or drop the bit under trial by the comparator decision
  function automatic logic [RESULT_BITS-1:0] decide(input logic [RESULT_BITS-1:0] trial,
                                                    input logic [BW-1:0]          idx,
                                                    input logic                   keep);
    return keep ? trial : (trial & ~bit_mask(idx));
  endfunction

  sar_adc_pkg::conv_state_t state_reg, state_next;
  logic [CW-1:0]          tick_reg,   tick_next;
  logic [BW-1:0]          bit_reg,    bit_next;
  logic [RESULT_BITS-1:0] trial_reg,  trial_next;
  logic                   done_pulse;

  always_comb
  begin
    state_next = state_reg;
    tick_next  = tick_reg;
    bit_next   = bit_reg;
    trial_next = trial_reg;
    done_pulse = 1'b0;
    unique case (state_reg)
      sar_adc_pkg::ST_ACQUIRE:
      begin
        if (cnv_rise)
        begin
          state_next = sar_adc_pkg::ST_CONVERT;
          tick_next  = '0;
          bit_next   = BW'(RESULT_BITS - 1);
          trial_next = bit_mask(BW'(RESULT_BITS - 1));
        end
      end
      sar_adc_pkg::ST_CONVERT:
      begin
        // further strobe edges are ignored until done
        if (tick_reg == CW'(STEP_CYCLES - 1))
        begin
          tick_next = '0;
          // settle the bit under trial, then try the next lower one
          trial_next = decide(trial_reg, bit_reg, comparator_i);
          if (bit_reg == '0)
          begin
            state_next = sar_adc_pkg::ST_ACQUIRE;
            done_pulse = 1'b1;
          end
          else
          begin
            bit_next   = bit_reg - BW'(1);
            trial_next = decide(trial_reg, bit_reg, comparator_i) | bit_mask(bit_reg - BW'(1));
          end
        end
        else
          tick_next = tick_reg + CW'(1);
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_reg <= sar_adc_pkg::ST_ACQUIRE;
      tick_reg  <= '0;
      bit_reg   <= '0;
      trial_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      tick_reg  <= tick_next;
      bit_reg   <= bit_next;
      trial_reg <= trial_next;
    end
  end

  // ==========================================================
  // output shifter
  logic [RESULT_BITS-1:0] shift_reg, shift_next;

  always_comb
  begin
    shift_next = shift_reg;
    // straight binary code of this very conversion; the load wins over a shift
    if (done_pulse)
      shift_next = decide(trial_reg, bit_reg, comparator_i);
    else if (sck_rise && (chain_mode || !pin_level))
      shift_next = {shift_reg[RESULT_BITS-2:0], chain_mode & pin_level};
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      shift_reg <= '0;
    else
      shift_reg <= shift_next;
  end

  // ==========================================================
  // busy and power flags
  logic busy_reg,  busy_next;
  logic power_reg, power_next;

  always_comb
  begin
    busy_next  = busy_reg;
    power_next = power_reg;
    if (cnv_rise && state_reg == sar_adc_pkg::ST_ACQUIRE)
    begin
      busy_next  = 1'b1;
      power_next = 1'b1;
    end
    if (done_pulse)
    begin
      busy_next  = 1'b0;
      power_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      busy_reg  <= 1'b0;
      power_reg <= 1'b0;
    end
    else
    begin
      busy_reg  <= busy_next;
      power_reg <= power_next;
    end
  end

  // ==========================================================
  // pin side outputs, registered
  logic sample_reg, sample_next;
  logic oe_n_reg,   oe_n_next;

  always_comb
  begin
    // the sampling switch opens on the same edge the conversion starts
    sample_next = (state_next == sar_adc_pkg::ST_ACQUIRE);
    // chain mode always drives; normal mode follows the enable pin
    oe_n_next   = chain_mode ? 1'b0 : pin_level;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sample_reg <= 1'b1;
      oe_n_reg   <= 1'b1;
    end
    else
    begin
      sample_reg <= sample_next;
      oe_n_reg   <= oe_n_next;
    end
  end

  // ==========================================================
  // outputs
  assign busy_o             = busy_reg;
  assign power_up_o         = power_reg;
  assign sample_switch_o    = sample_reg;
  assign sampling_cap_dac_o = trial_reg;
  assign sdo_o              = shift_reg[RESULT_BITS-1];
  assign sdo_oe_n_o         = oe_n_reg;

endmodule

/* testbench/sar_adc_assertions.sv */
// port checks for the sar converter control block
`timescale 1ns/1ps
module sar_adc_assertions #(
  parameter int RESULT_BITS = 16,
  parameter int CONV_CYCLES = 105
) (
  input wire logic                   mclk_i,
  input wire logic                   reset_i,
  input wire logic                   convert_strobe_i,
  input wire logic                   chain_select_i,
  input wire logic                   read_enable_or_chain_in_i,
  input wire logic                   sck_i,
  input wire logic                   comparator_i,
  input wire logic [RESULT_BITS-1:0] sampling_cap_dac_o,
  input wire logic                   sample_switch_o,
  input wire logic                   power_up_o,
  input wire logic                   busy_o,
  input wire logic                   sdo_o,
  input wire logic                   sdo_oe_n_o
);
  localparam int CONV_LEN = CONV_CYCLES / RESULT_BITS * RESULT_BITS;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_len; $rose(busy_o) |-> ##CONV_LEN $fell(busy_o); endproperty
  a_len: assert property (p_len) else $error("len");
  property p_pwr; busy_o == power_up_o; endproperty
  a_pwr: assert property (p_pwr) else $error("pwr");
  property p_acq; $rose(busy_o) |-> !sample_switch_o; endproperty
  a_acq: assert property (p_acq) else $error("acq");
  property p_trial; $rose(busy_o) |-> sampling_cap_dac_o == {1'h1, {(RESULT_BITS-1){1'h0}}}; endproperty
  a_trial: assert property (p_trial) else $error("trial");
  property p_msb; $fell(busy_o) |-> sdo_o == sampling_cap_dac_o[RESULT_BITS-1]; endproperty
  a_msb: assert property (p_msb) else $error("msb");
  property p_shift; sdo_o != $past(sdo_o) && !$fell(busy_o) |-> $past(sck_i, 3); endproperty
  a_shift: assert property (p_shift) else $error("shift");
  property p_oe; (!chain_select_i && !read_enable_or_chain_in_i)[*5] |-> !sdo_oe_n_o; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_chain; chain_select_i[*5] |-> !sdo_oe_n_o; endproperty
  a_chain: assert property (p_chain) else $error("chain");
endmodule

bind sar_adc_conversion_and_serial_readout sar_adc_assertions #(.RESULT_BITS(RESULT_BITS),
  .CONV_CYCLES(CONV_CYCLES)) checks (.*);

/* testbench/host_model.sv */
// host and comparator model facing the sar converter control block
`timescale 1ns/1ps
module host_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] dac_i,
  input  wire logic [15:0] level_i,
  output logic             convert_strobe_o,
  output logic             sck_o,
  output logic             comparator_o
);
  assign comparator_o = dac_i <= level_i;
  initial convert_strobe_o = 1'h0;
  // serial clock stands low outside frames
  initial sck_o = 1'h0;
  task automatic convert(logic again);
    // a strobe left high falls only once the previous conversion is over
    if (convert_strobe_o)
    begin
      @(posedge mclk_i);
      #1 convert_strobe_o = 1'h0;
      repeat (4) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    #1 convert_strobe_o = 1'h1;
    repeat (4) @(posedge mclk_i);
    #1 convert_strobe_o = 1'h0;
    // optional second rise 40 ns after the start, held past the conversion
    repeat (4) @(posedge mclk_i);
    #1 convert_strobe_o = again;
  endtask
  task automatic sck_pulse();
    @(posedge mclk_i);
    #1 sck_o = 1'h1;
    repeat (16) @(posedge mclk_i);
    #1 sck_o = 1'h0;
    repeat (15) @(posedge mclk_i);
  endtask
endmodule

/* testbench/tb.sv */
// self-checking bench for the sar converter control block
`timescale 1ns/1ps
`include "sar_adc_defs.svh"
module tb;
  logic        mclk_i = 0, reset_i = 1, chain_select_i = 0, rdc = 0;
  logic        convert_strobe_i, sck_i, comparator_i, sample_switch_o, power_up_o, busy_o, sdo_o, sdo_oe_n_o;
  logic [15:0] sampling_cap_dac_o, lvl = 16'h0;
  logic [31:0] w;
  int          fails = 0, samples_checked = 0;
  logic [15:0] vals [4] = '{16'h0000, 16'hffff, 16'ha5c3, 16'h8001};
  always #2.5 mclk_i = ~mclk_i;
  host_model host (.mclk_i, .dac_i(sampling_cap_dac_o), .level_i(lvl), .convert_strobe_o(convert_strobe_i),
    .sck_o(sck_i), .comparator_o(comparator_i));
  sar_adc_conversion_and_serial_readout #(.CONV_CYCLES(32)) dut (
    .mclk_i                    (mclk_i),
    .reset_i                   (reset_i),
    .convert_strobe_i          (convert_strobe_i),
    .chain_select_i            (chain_select_i),
    .read_enable_or_chain_in_i (rdc),
    .sck_i                     (sck_i),
    .comparator_i              (comparator_i),
    .sampling_cap_dac_o        (sampling_cap_dac_o),
    .sample_switch_o           (sample_switch_o),
    .power_up_o                (power_up_o),
    .busy_o                    (busy_o),
    .sdo_o                     (sdo_o),
    .sdo_oe_n_o                (sdo_oe_n_o)
  );
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      fails++;
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // convert v, then read n bits while up is fed to the chain input
  task automatic conv_read(logic [15:0] v, logic again, int n, logic [15:0] up);
    int k = 0;
    lvl = v;
    host.convert(again);
    chk("busy high", 1'h1, busy_o);
    while (busy_o !== 1'h0 && k < 40)
    begin
      @(posedge mclk_i);
      #1 k++;
    end
    chk("busy", 1'h0, busy_o);
    if (k == 40)
      end_of_test();
    w = 32'h0;
    for (int i = 0; i < n; i++)
    begin
      #1 w = {w[30:0], sdo_o};
      rdc = up[15 - i[3:0]];
      host.sck_pulse();
    end
    #1;
  endtask
  initial
  begin
    repeat (20) @(posedge mclk_i);
    #1 reset_i = 0;
    repeat (`POR_WAIT_US * 1000 * 1000 / `CLK_PERIOD_PS) @(posedge mclk_i);
    foreach (vals[j])
    begin
      conv_read(vals[j], j == 2, 16, 16'h0);
      chk("word", {16'h0, vals[j]}, w);
      chk("oe", 1'h0, sdo_oe_n_o);
    end
    rdc = 1'h1;
    repeat (6) @(posedge mclk_i);
    #1 chk("oe off", 1'h1, sdo_oe_n_o);
    chain_select_i = 1'h1;
    conv_read(16'h5a3c, 1'h0, 32, 16'hc3a5);
    chk("chain", 32'h5a3cc3a5, w);
    end_of_test();
  end
endmodule
